// ---- fpm_asserts.sv ----
// port assertions for the flow monitor
`timescale 1ns/1ns
module fpm_asserts #(
  parameter int unsigned PULSE_CYC = 4,
  parameter int unsigned GAP_CYC = 8
)
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic wr_i,
  input wire logic start_key_i,
  input wire logic stop_key_i,
  input wire logic remote_sw_i,
  input wire logic relay1_o,
  input wire logic relay2_o,
  input wire logic pulse_sink_o,
  input wire logic eod_o,
  input wire logic flow_alarm_n_o,
  input wire logic stop_led_o,
  input wire logic [7:0] err_code_o
);
  logic [31:0] hi_ff;
  logic [31:0] gap_ff;
  logic [3:0] quiet_ff;
  logic [3:0] key_ff;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  always_ff @(posedge mclk_i)
  begin
    hi_ff <= pulse_sink_o ? hi_ff + 32'h1 : 32'h0;
    if (!reset_n_i)
      gap_ff <= 32'hffff;
    else if ($rose(pulse_sink_o))
      gap_ff <= 32'h1;
    else if (gap_ff < 32'hffff)
      gap_ff <= gap_ff + 32'h1;
  end
  // cycles since a stop source or a write, and since a start source
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i || stop_key_i || remote_sw_i || wr_i)
      quiet_ff <= 4'h0;
    else if (quiet_ff != 4'hf)
      quiet_ff <= quiet_ff + 4'h1;
    if (!reset_n_i || start_key_i || remote_sw_i)
      key_ff <= 4'h0;
    else if (key_ff != 4'hf)
      key_ff <= key_ff + 4'h1;
  end
  a_alarm_drops_relays: assert property (!flow_alarm_n_o |-> !relay1_o && !relay2_o && stop_led_o)
    else $error("relay on during alarm");
  a_relay2_needs_relay1: assert property (relay2_o |-> relay1_o)
    else $error("relay 2 without relay 1");
  a_pulse_width: assert property ($fell(pulse_sink_o) |-> hi_ff == PULSE_CYC)
    else $error("output pulse length wrong");
  a_pulse_rate: assert property ($rose(pulse_sink_o) |-> gap_ff >= GAP_CYC)
    else $error("output pulses too close");
  a_alarm_latched: assert property ($rose(flow_alarm_n_o) |-> quiet_ff < 4'hc)
    else $error("alarm cleared without stop");
  a_alarm_holds: assert property (!flow_alarm_n_o && quiet_ff == 4'hf |=> !flow_alarm_n_o)
    else $error("alarm dropped while pending");
  a_eod_held: assert property ($fell(eod_o) |-> key_ff < 4'hc)
    else $error("end of delivery dropped without start");
  a_code_legal: assert property (err_code_o != 8'h00 |-> err_code_o inside {8'h0d, 8'h12})
    else $error("unknown error code");
endmodule
bind fpm_top fpm_asserts #(.PULSE_CYC(PULSE_CYC), .GAP_CYC(GAP_CYC)) i_chk (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .wr_i(wr_i), .start_key_i(start_key_i),
  .stop_key_i(stop_key_i), .remote_sw_i(remote_sw_i), .relay1_o(relay1_o),
  .relay2_o(relay2_o), .pulse_sink_o(pulse_sink_o), .eod_o(eod_o),
  .flow_alarm_n_o(flow_alarm_n_o), .stop_led_o(stop_led_o), .err_code_o(err_code_o));

// ---- fpm_map.svh ----
// register offsets, fields, reset values and timing figures of the flow monitor
`ifndef FPM_MAP_SVH
`define FPM_MAP_SVH
`define FPM_A_CTRL 6'h00
`define FPM_A_VMIN 6'h04
`define FPM_A_ACC 6'h08
`define FPM_A_BATCH 6'h0c
`define FPM_A_PRESTOP 6'h10
`define FPM_A_DELAY 6'h14
`define FPM_A_SCALE 6'h18
`define FPM_A_STATUS 6'h1c
`define FPM_A_TOTAL 6'h20
`define FPM_A_BTOT 6'h24
`define FPM_B_QUAD 0
`define FPM_B_PCHK 1
`define FPM_B_PRESET 2
`define FPM_B_REMFN 3
`define FPM_B_EXENC 4
`define FPM_CTRL_W 5
`define FPM_RST_CTRL 5'h00
`define FPM_RST_VMIN 16'h0064
`define FPM_RST_ACC 8'h01
`define FPM_RST_BATCH 24'h000000
`define FPM_RST_PRESTOP 24'h000000
`define FPM_RST_DELAY 13'h0000
`define FPM_RST_SCALE 16'h0001
`define FPM_DELAY_MAX_S 4799
`define FPM_CLK_MHZ 125
`define FPM_PULSE_MS 10
`define FPM_PULSE_MAX_PER_S 49
`define FPM_FLASH_MS 500
`define FPM_DEB_LEN 4
`define FPM_ERR_MISS 8'h0d
`define FPM_ERR_SIM 8'h12
`endif

// ---- fpm_pkg.sv ----
// types shared by the flow monitor
package fpm_pkg;
  typedef enum logic [1:0] {DLV_IDLE, DLV_RUN, DLV_DONE} fpm_dlv_e;
  typedef logic [23:0] fpm_qty_t;
endpackage

// ---- fpm_sensor.sv ----
// two-channel flow sensor model, 24 cycles a pulse
`timescale 1ns/1ns
module fpm_sensor (
  input wire logic mclk_i,
  input wire logic fire_i,
  input wire logic [1:0] mode_i,
  output logic ch1_o,
  output logic ch2_o
);
  logic [4:0] ph_ff;
  always_ff @(posedge mclk_i)
  begin
    if (!fire_i || ph_ff == 5'h17)
      ph_ff <= 5'h00;
    else
      ph_ff <= ph_ff + 5'h01;
  end
  // ch2 leads, ch1 a quarter later; mode 1 drops ch1, mode 2 aligns it
  assign ch2_o = fire_i && ph_ff < 5'h0c;
  assign ch1_o = fire_i && (mode_i == 2'h2 ? ph_ff < 5'h0c :
    mode_i == 2'h0 && ph_ff >= 5'h06 && ph_ff < 5'h12);
endmodule

// ---- fpm_top.sv ----
// flow pulse monitor: quadrature check, relays, output pulse, end of delivery, alarm
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ns
`include "fpm_map.svh"
module fpm_top
  import fpm_pkg::*;
#(
  parameter int unsigned PULSE_CYC = `FPM_PULSE_MS * `FPM_CLK_MHZ * 1000,
  parameter int unsigned GAP_CYC =
    (`FPM_CLK_MHZ * 1000000 + `FPM_PULSE_MAX_PER_S - 1) / `FPM_PULSE_MAX_PER_S,
  parameter int unsigned SEC_CYC = `FPM_CLK_MHZ * 1000000,
  parameter int unsigned FLASH_CYC = `FPM_FLASH_MS * `FPM_CLK_MHZ * 1000
)
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [5:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic ch1_i,
  input wire logic ch2_i,
  input wire logic start_key_i,
  input wire logic stop_key_i,
  input wire logic remote_sw_i,
  input wire logic cal_sw_i,
  output logic relay1_o,
  output logic relay2_o,
  output logic pulse_sink_o,
  output logic eod_o,
  output logic flow_alarm_n_o,
  output logic stop_led_o,
  output logic [7:0] err_code_o,
  output logic cal_sw_o
);
  localparam int unsigned NIN = 6;
  logic [`FPM_CTRL_W-1:0] ctrl_ff;
  logic [15:0] vmin_ff;
  logic [7:0] acc_ff;
  fpm_qty_t batch_ff;
  fpm_qty_t prestop_ff;
  logic [12:0] delay_ff;
  logic [15:0] scale_ff;
  logic [31:0] rdata_ff;
  logic [NIN-1:0] raw;
  logic [NIN-1:0] deb_ff;
  logic [NIN-1:0] deb_d_ff;
  logic [NIN-1:0] rise;
  logic quad_en;
  logic chk_en;
  logic preset_en;
  logic flow_pulse;
  logic start_ev;
  logic stop_ev;
  logic last_ch_ff;
  logic any_edge_ff;
  logic miss_ev;
  logic sim_ev;
  logic [16:0] run_ff;
  logic [16:0] miss_acc_ff;
  logic [16:0] sim_acc_ff;
  logic [31:0] dev2;
  logic miss_trip;
  logic sim_trip;
  logic miss_over;
  logic sim_over;
  logic alarm_ff;
  logic miss_flag_ff;
  logic sim_flag_ff;
  logic [31:0] flash_cnt_ff;
  logic flash_on_ff;
  fpm_dlv_e dlv_ff;
  logic [31:0] sec_cnt_ff;
  logic [12:0] dly_cnt_ff;
  logic [15:0] pre_ff;
  logic digit;
  fpm_qty_t total_ff;
  fpm_qty_t btot_ff;
  fpm_qty_t remain;
  logic [7:0] owed_ff;
  logic [31:0] pls_cnt_ff;
  logic fire;
  logic batch_hit;

  assign raw = {cal_sw_i, remote_sw_i, stop_key_i, start_key_i, ch2_i, ch1_i};
  assign quad_en = ctrl_ff[`FPM_B_QUAD];
  assign preset_en = ctrl_ff[`FPM_B_PRESET];
  assign chk_en = quad_en & ctrl_ff[`FPM_B_PCHK];

  // debounce every channel, key and switch input; channels then give clean edges
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++)
    begin : g_deb
      logic [`FPM_DEB_LEN-1:0] hist_ff;
      always_ff @(posedge mclk_i)
      begin
        if (!reset_n_i)
        begin
          hist_ff <= '0;
          deb_ff[gi] <= 1'b0;
        end
        else
        begin
          hist_ff <= {hist_ff[`FPM_DEB_LEN-2:0], raw[gi]};
          if (&hist_ff)
            deb_ff[gi] <= 1'b1;
          else if (~|hist_ff)
            deb_ff[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
      deb_d_ff <= '0;
    else
      deb_d_ff <= deb_ff;
  end
  assign rise = deb_ff & ~deb_d_ff;

  // flow is counted on channel 2 in quadrature, channel 1 otherwise
  assign flow_pulse = quad_en ? rise[1] : rise[0];
  assign start_ev = rise[2] | (rise[4] & ~ctrl_ff[`FPM_B_REMFN]);
  assign stop_ev = rise[3] | (rise[4] & ctrl_ff[`FPM_B_REMFN]);

  // quadrature edge ordering
  assign sim_ev = chk_en & rise[0] & rise[1];
  assign miss_ev = chk_en & (rise[0] ^ rise[1]) & any_edge_ff
                   & (last_ch_ff == rise[1]);
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      last_ch_ff <= 1'b0;
      any_edge_ff <= 1'b0;
    end
    else if (rise[0] ^ rise[1])
    begin
      last_ch_ff <= rise[1];
      any_edge_ff <= 1'b1;
    end
  end

  // twice the allowed deviation, in pulses
  assign dev2 = (32'd4 * {16'h0000, vmin_ff} * {24'h000000, acc_ff}) / 32'd100;
  assign miss_over = {15'h0000, miss_acc_ff} > dev2;
  assign sim_over = {15'h0000, sim_acc_ff} > dev2;
  // trips are events, so a stop can clear the alarm mid-run
  assign miss_trip = miss_ev && {15'h0000, miss_acc_ff} >= dev2;
  assign sim_trip = sim_ev && {15'h0000, sim_acc_ff} >= dev2;

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i || !chk_en)
    begin
      run_ff <= '0;
      miss_acc_ff <= '0;
      sim_acc_ff <= '0;
    end
    else if (flow_pulse && run_ff >= {vmin_ff, 1'b0} - 17'd1)
    begin
      run_ff <= '0;
      miss_acc_ff <= '0;
      sim_acc_ff <= '0;
    end
    else
    begin
      if (flow_pulse)
        run_ff <= run_ff + 17'd1;
      if (miss_ev && !miss_over)
        miss_acc_ff <= miss_acc_ff + 17'd1;
      if (sim_ev && !sim_over)
        sim_acc_ff <= sim_acc_ff + 17'd1;
    end
  end

  // latched alarm; a new trip wins over the stop key
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      alarm_ff <= 1'b0;
      miss_flag_ff <= 1'b0;
      sim_flag_ff <= 1'b0;
    end
    else if (chk_en && (miss_trip || sim_trip))
    begin
      alarm_ff <= 1'b1;
      miss_flag_ff <= miss_flag_ff | miss_trip;
      sim_flag_ff <= sim_flag_ff | sim_trip;
    end
    else if (stop_ev || !quad_en)
    begin
      alarm_ff <= 1'b0;
      miss_flag_ff <= 1'b0;
      sim_flag_ff <= 1'b0;
    end
  end

  // error code flashing
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i || !alarm_ff)
    begin
      flash_cnt_ff <= '0;
      flash_on_ff <= 1'b0;
    end
    else if (flash_cnt_ff >= FLASH_CYC - 1)
    begin
      flash_cnt_ff <= '0;
      flash_on_ff <= ~flash_on_ff;
    end
    else
      flash_cnt_ff <= flash_cnt_ff + 32'd1;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
      err_code_o <= 8'h00;
    else if (alarm_ff && flash_on_ff)
      err_code_o <= miss_flag_ff ? `FPM_ERR_MISS : `FPM_ERR_SIM;
    else
      err_code_o <= 8'h00;
  end

  // totals keep counting whatever the alarm state
  assign digit = flow_pulse && pre_ff >= scale_ff - 16'd1;
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      pre_ff <= '0;
      total_ff <= '0;
    end
    else if (flow_pulse)
    begin
      pre_ff <= digit ? 16'h0000 : pre_ff + 16'd1;
      if (digit)
        total_ff <= total_ff + 24'd1;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i || (start_ev && dlv_ff != DLV_RUN && !alarm_ff))
      btot_ff <= '0;
    else if (digit && dlv_ff == DLV_RUN)
      btot_ff <= btot_ff + 24'd1;
  end

  // delivery sequence
  assign batch_hit = preset_en && btot_ff >= batch_ff;
  assign remain = batch_hit ? 24'h000000 : batch_ff - btot_ff;
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
      dlv_ff <= DLV_IDLE;
    else
    begin
      unique case (dlv_ff)
        DLV_IDLE, DLV_DONE:
          if (start_ev && !alarm_ff)
            dlv_ff <= DLV_RUN;
        DLV_RUN:
          if (stop_ev || batch_hit)
            dlv_ff <= DLV_DONE;
      endcase
    end
  end

  // start delay in whole seconds
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i || dlv_ff != DLV_RUN)
    begin
      sec_cnt_ff <= '0;
      dly_cnt_ff <= '0;
    end
    else if (dly_cnt_ff < delay_ff)
    begin
      if (sec_cnt_ff >= SEC_CYC - 1)
      begin
        sec_cnt_ff <= '0;
        dly_cnt_ff <= dly_cnt_ff + 13'd1;
      end
      else
        sec_cnt_ff <= sec_cnt_ff + 32'd1;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      relay1_o <= 1'b0;
      relay2_o <= 1'b0;
      stop_led_o <= 1'b0;
      flow_alarm_n_o <= 1'b1;
      eod_o <= 1'b0;
      cal_sw_o <= 1'b0;
    end
    else
    begin
      relay1_o <= dlv_ff == DLV_RUN && !alarm_ff;
      relay2_o <= preset_en && dlv_ff == DLV_RUN && !alarm_ff
                  && dly_cnt_ff >= delay_ff
                  && remain > prestop_ff;
      stop_led_o <= alarm_ff;
      flow_alarm_n_o <= ~(alarm_ff && quad_en);
      eod_o <= dlv_ff == DLV_DONE;
      cal_sw_o <= ctrl_ff[`FPM_B_EXENC] & deb_ff[5];
    end
  end

  // output pulse with rate limit; up to 255 owed pulses are kept
  assign fire = owed_ff != 8'h00 && pls_cnt_ff == 32'd0;
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
      owed_ff <= '0;
    else if (digit && !fire && owed_ff != 8'hff)
      owed_ff <= owed_ff + 8'd1;
    else if (fire && !digit)
      owed_ff <= owed_ff - 8'd1;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      pls_cnt_ff <= '0;
      pulse_sink_o <= 1'b0;
    end
    else if (fire)
    begin
      pls_cnt_ff <= GAP_CYC - 1;
      pulse_sink_o <= 1'b1;
    end
    else if (pls_cnt_ff != 32'd0)
    begin
      pls_cnt_ff <= pls_cnt_ff - 32'd1;
      if (pls_cnt_ff == GAP_CYC - PULSE_CYC)
        pulse_sink_o <= 1'b0;
    end
  end

  // register port
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      ctrl_ff <= `FPM_RST_CTRL;
      vmin_ff <= `FPM_RST_VMIN;
      acc_ff <= `FPM_RST_ACC;
      batch_ff <= `FPM_RST_BATCH;
      prestop_ff <= `FPM_RST_PRESTOP;
      delay_ff <= `FPM_RST_DELAY;
      scale_ff <= `FPM_RST_SCALE;
    end
    else if (wr_i)
    begin
      unique case (addr_i)
        `FPM_A_CTRL: ctrl_ff <= wdata_i[`FPM_CTRL_W-1:0];
        `FPM_A_VMIN: vmin_ff <= wdata_i[15:0];
        `FPM_A_ACC: acc_ff <= wdata_i[7:0];
        `FPM_A_BATCH: batch_ff <= wdata_i[23:0];
        `FPM_A_PRESTOP: prestop_ff <= wdata_i[23:0];
        `FPM_A_DELAY:
          delay_ff <= (wdata_i[12:0] > 13'(`FPM_DELAY_MAX_S)) ?
                      13'(`FPM_DELAY_MAX_S) : wdata_i[12:0];
        `FPM_A_SCALE: scale_ff <= wdata_i[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i || !rd_i)
      rdata_ff <= '0;
    else
    begin
      unique case (addr_i)
        `FPM_A_CTRL: rdata_ff <= {27'h0, ctrl_ff};
        `FPM_A_VMIN: rdata_ff <= {16'h0, vmin_ff};
        `FPM_A_ACC: rdata_ff <= {24'h0, acc_ff};
        `FPM_A_BATCH: rdata_ff <= {8'h0, batch_ff};
        `FPM_A_PRESTOP: rdata_ff <= {8'h0, prestop_ff};
        `FPM_A_DELAY: rdata_ff <= {19'h0, delay_ff};
        `FPM_A_SCALE: rdata_ff <= {16'h0, scale_ff};
        `FPM_A_STATUS:
          rdata_ff <= {24'h0, dlv_ff, relay2_o, relay1_o, eod_o,
                       sim_flag_ff, miss_flag_ff, alarm_ff};
        `FPM_A_TOTAL: rdata_ff <= {8'h0, total_ff};
        `FPM_A_BTOT: rdata_ff <= {8'h0, btot_ff};
        default: rdata_ff <= '0;
      endcase
    end
  end
  assign rdata_o = rdata_ff;
endmodule

// ---- test_flow_pulse_monitor_outputs.sv ----
// self-checking bench for the flow monitor
`timescale 1ns/1ns
`include "fpm_map.svh"
module test_flow_pulse_monitor_outputs;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0, rd = 1'b0, start = 1'b0, stop = 1'b0, remote = 1'b0;
  logic cal = 1'b0, fire = 1'b0, sink_q = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [31:0] rdata, v, t0;
  logic ch1, ch2, relay1, relay2, sink, eod, alarm_n, led, cal_o;
  logic [7:0] code;
  int errors = 0, checks_done = 0, npulse = 0, cyc = 0;
  always #4 mclk_i = ~mclk_i;
  fpm_sensor i_sen (.mclk_i(mclk_i), .fire_i(fire), .mode_i(mode), .ch1_o(ch1), .ch2_o(ch2));
  fpm_top #(.PULSE_CYC(4), .GAP_CYC(8), .SEC_CYC(10), .FLASH_CYC(6)) i_dut (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .ch1_i(ch1), .ch2_i(ch2), .start_key_i(start),
    .stop_key_i(stop), .remote_sw_i(remote), .cal_sw_i(cal), .relay1_o(relay1),
    .relay2_o(relay2), .pulse_sink_o(sink), .eod_o(eod), .flow_alarm_n_o(alarm_n),
    .stop_led_o(led), .err_code_o(code), .cal_sw_o(cal_o));
  always @(posedge mclk_i)
  begin
    cyc++;
    if (sink === 1'b1 && sink_q === 1'b0)
      npulse++;
    sink_q <= sink;
    if (cyc == 20000)
    begin
      errors++;
      $display("BAD %0t timeout", $time);
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t %s got %h", $time, what, got);
    end
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [5:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic press(input int k);
    @(posedge mclk_i);
    start <= (k == 0);
    stop <= (k == 1);
    remote <= (k == 2);
    repeat (8) @(posedge mclk_i);
    start <= 1'b0;
    stop <= 1'b0;
    remote <= 1'b0;
    repeat (8) @(posedge mclk_i);
  endtask
  task automatic flow(input int n, input logic [1:0] m);
    @(posedge mclk_i);
    mode <= m;
    fire <= 1'b1;
    repeat (n * 24) @(posedge mclk_i);
    fire <= 1'b0;
    repeat (12) @(posedge mclk_i);
  endtask
  task automatic wait_code(input logic [7:0] e);
    for (int i = 0; i < 40 && code !== e; i++) @(posedge mclk_i);
    chk({24'h0, code}, {24'h0, e}, "code");
  endtask
  task automatic t_regs();
    rd_reg(`FPM_A_VMIN, v);
    chk(v, 32'h64, "vmin");
    rd_reg(6'h3c, v);
    chk(v, 32'h0, "unmapped");
    wr_reg(`FPM_A_DELAY, 32'h1388);
    rd_reg(`FPM_A_DELAY, v);
    chk(v, 32'h12bf, "delay clamp");
    $display("regs done");
  endtask
  task automatic t_preset();
    wr_reg(`FPM_A_CTRL, 32'h4);
    wr_reg(`FPM_A_BATCH, 32'h6);
    wr_reg(`FPM_A_PRESTOP, 32'h2);
    wr_reg(`FPM_A_DELAY, 32'h2);
    press(0);
    chk({relay2, relay1}, 2'b01, "delay");
    repeat (16) @(posedge mclk_i);
    chk({relay2, relay1}, 2'b11, "relay2");
    flow(4, 2'h0);
    chk({relay2, relay1}, 2'b01, "prestop");
    flow(2, 2'h0);
    chk({eod, relay1}, 2'b10, "batch end");
    $display("preset done");
  endtask
  task automatic t_single();
    wr_reg(`FPM_A_CTRL, 32'h0);
    wr_reg(`FPM_A_SCALE, 32'h2);
    press(0);
    v = npulse;
    flow(6, 2'h0);
    chk({eod, relay2, relay1}, 3'b001, "single run");
    chk(npulse - v, 32'h3, "out pulses");
    wr_reg(`FPM_A_SCALE, 32'h1);
    press(1);
    chk({eod, relay1}, 2'b10, "stopped");
    $display("single done");
  endtask
  task automatic t_quad();
    wr_reg(`FPM_A_CTRL, 32'h3);
    wr_reg(`FPM_A_VMIN, 32'h4);
    wr_reg(`FPM_A_ACC, 32'h19);
    press(0);
    flow(16, 2'h0);
    chk({alarm_n, relay1}, 2'b11, "clean");
    rd_reg(`FPM_A_TOTAL, t0);
    flow(10, 2'h1);
    rd_reg(`FPM_A_TOTAL, v);
    chk(v - t0, 32'ha, "total");
    chk({alarm_n, relay1, relay2, led}, 4'b0001, "alarm");
    rd_reg(`FPM_A_STATUS, v);
    chk(v[2:0], 3'b011, "miss flag");
    wait_code(8'h0d);
    press(1);
    chk(alarm_n, 1'b1, "cleared");
    flow(10, 2'h2);
    wait_code(8'h12);
    press(1);
    wr_reg(`FPM_A_CTRL, 32'h1);
    flow(10, 2'h1);
    chk(alarm_n, 1'b1, "unchecked");
    $display("quad done");
  endtask
  task automatic t_remote();
    wr_reg(`FPM_A_CTRL, 32'h0);
    press(2);
    chk(relay1, 1'b1, "remote start");
    wr_reg(`FPM_A_CTRL, 32'h8);
    press(2);
    chk({eod, relay1}, 2'b10, "remote stop");
    cal <= 1'b1;
    repeat (10) @(posedge mclk_i);
    chk(cal_o, 1'b0, "cal off");
    wr_reg(`FPM_A_CTRL, 32'h10);
    repeat (4) @(posedge mclk_i);
    chk(cal_o, 1'b1, "cal on");
    $display("remote done");
  endtask
  initial
  begin
    repeat (8) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    t_regs();
    t_preset();
    t_single();
    t_quad();
    t_remote();
    conclude();
  end
endmodule
